// ==== verilog/mpi_pkg.sv ====
// package: constants for the manchester programming interface
// assumes a 20 MHz system clock and a 32-bit apb register port
package mpi_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned NV_WRITE_MS     = 20;
  localparam int unsigned NV_WRITE_CYC    = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam int unsigned ACCESS_MS       = 500;
  localparam int unsigned ACCESS_CYC      = CLK_HZ / 1000 * ACCESS_MS;
  localparam logic [15:0] RX_MEAS_MAX     = 16'hffff;
  // frame layout, rx bit counts after the two sync bits, tx count including them
  localparam logic [5:0]  RD_FRAME_BITS   = 6'h11;
  localparam logic [5:0]  WR_FRAME_BITS   = 6'h31;
  localparam int unsigned TX_BITS         = 51;
  localparam logic [6:0]  ACCESS_ADDR     = 7'h79;
  localparam logic [31:0] CUST_CODE       = 32'hc41d3432;
  // memory regions
  localparam logic [6:0]  NV_LAST         = 7'h1f;
  localparam logic [6:0]  VOL_FIRST       = 7'h40;
  // field select codes
  localparam logic [1:0]  FS_ALL          = 2'h0;
  localparam logic [1:0]  FS_LOW          = 2'h1;
  localparam logic [1:0]  FS_HIGH         = 2'h2;
  // pulse classes in poll mode (ticks)
  localparam logic [7:0]  OUT_MIN         = 8'h0f;
  localparam logic [7:0]  OUT_MAX         = 8'h13;
  localparam logic [7:0]  SMP_MIN         = 8'h1f;
  localparam logic [7:0]  SMP_MAX         = 8'h27;
  localparam logic [7:0]  DIA_MIN         = 8'h38;
  localparam logic [7:0]  DIA_MAX         = 8'h46;
  localparam logic [1:0]  PC_NONE         = 2'h0;
  localparam logic [1:0]  PC_OUTPUT       = 2'h1;
  localparam logic [1:0]  PC_SAMPLE       = 2'h2;
  localparam logic [1:0]  PC_DIAG         = 2'h3;
  // apb register offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_TICK        = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_MEMIDX      = 8'h0c;
  localparam logic [7:0]  OFS_MEMDATA     = 8'h10;
  localparam logic [7:0]  OFS_BITTIME     = 8'h14;
  // reset values
  localparam logic [2:0]  CTRL_RST        = 3'h0;
  localparam logic [15:0] TICK_RST        = 16'h0050;
endpackage

// ==== verilog/mpi_crc3.sv ====
// serial crc, polynomial x^3+x+1, seeded with all ones
// assumes clear is pulsed before the first covered bit
`timescale 1ns/100ps
module mpi_crc3 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // bit stream
  input  wire logic       clear,
  input  wire logic       bit_valid,
  input  wire logic       bit_val,
  // remainder, zero after a good frame including its check bits
  output logic [2:0]      crc
);
  logic fb;
  assign fb = bit_val ^ crc[2];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc <= 3'h7;
    end else if (clear) begin
      crc <= 3'h7;
    end else if (bit_valid) begin
      crc <= {crc[1], crc[0] ^ fb, fb};
    end
  end
endmodule

// ==== verilog/mpi_rx.sv ====
// manchester receiver with bit time measured from the sync bits
// assumes the line rests low before a frame and inputs are synchronous
`timescale 1ns/100ps
module mpi_rx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // line
  input  wire logic        enable,
  input  wire logic        line,
  // decoded stream
  output logic             bit_valid,
  output logic             bit_val,
  output logic             frame_end,
  output logic [15:0]      bit_time
);
  import mpi_pkg::*;
  logic        line_q;
  logic [15:0] cnt;
  logic [1:0]  phase;
  logic        edge_seen;
  logic        rise;
  logic [15:0] t_accept;
  logic [16:0] t_end;
  assign edge_seen = line ^ line_q;
  assign rise      = line & ~line_q;
  // boundary edges fall near half a bit, so accept only past three quarters
  assign t_accept  = bit_time - {2'h0, bit_time[15:2]};
  assign t_end     = {1'b0, bit_time} + {2'h0, bit_time[15:1]};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_q    <= 1'b0;
      cnt       <= 16'h0;
      phase     <= 2'h0;
      bit_valid <= 1'b0;
      bit_val   <= 1'b0;
      frame_end <= 1'b0;
      bit_time  <= 16'h0;
    end else begin
      line_q    <= line;
      bit_valid <= 1'b0;
      frame_end <= 1'b0;
      if (cnt != RX_MEAS_MAX) cnt <= cnt + 16'h1;
      if (!enable) begin
        phase <= 2'h0;
        cnt   <= 16'h0;
      end else begin
        case (phase)
          2'h0: if (rise) begin
            cnt   <= 16'h0;
            phase <= 2'h1;
          end
          2'h1: if (rise) begin
            bit_time <= cnt + 16'h1;
            cnt      <= 16'h0;
            phase    <= 2'h2;
          end else if (cnt == RX_MEAS_MAX) begin
            phase <= 2'h0;
          end
          2'h2: if (edge_seen && cnt >= t_accept) begin
            bit_valid <= 1'b1;
            bit_val   <= ~line;
            cnt       <= 16'h0;
          end else if ({1'b0, cnt} >= t_end) begin
            frame_end <= 1'b1;
            phase     <= 2'h0;
          end
          default: phase <= 2'h0;
        endcase
      end
    end
  end
endmodule

// ==== verilog/mpi_top.sv ====
// manchester programming interface: frame decode, memory, read reply
// assumes prog_enable comes from a supply comparator, apb zero-wait master
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module mpi_top
  import mpi_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_CYC,
  parameter int unsigned ACCESS_CYCLES   = ACCESS_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // supply above program_enable_high_level
  input  wire logic        prog_enable,
  // measurement level for sensor_output_data_pin
  input  wire logic        sensor_level,
  // sensor_output_data_pin as three signals
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe
);
  typedef enum logic [5:0] {
    MPI_IDLE   = 6'b000001,
    MPI_RX     = 6'b000010,
    MPI_NVWAIT = 6'b000100,
    MPI_ACKHI  = 6'b001000,
    MPI_ACKLO  = 6'b010000,
    MPI_TX     = 6'b100000
  } mpi_state_t;

  function automatic logic [31:0] mpi_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [1:0] fs);
    case (fs)
      FS_LOW:  mpi_merge = {old_w[31:12], new_w[11:0]};
      FS_HIGH: mpi_merge = {old_w[31:26], new_w[25:12], old_w[11:0]};
      default: mpi_merge = new_w;
    endcase
  endfunction

  // covers the reply body only, the two sync bits stay outside the check
  function automatic logic [2:0] mpi_crc_fn(input logic [45:0] bits);
    logic [2:0] c;
    logic       f;
    c = 3'h7;
    f = 1'b0;
    for (int i = 45; i >= 0; i--) begin
      f = bits[i] ^ c[2];
      c = {c[1], c[0] ^ f, f};
    end
    mpi_crc_fn = c;
  endfunction

  mpi_state_t  state_reg;
  mpi_state_t  state_next;
  logic [31:0] mem_reg [0:127];
  logic [2:0]  ctrl_reg;
  logic [15:0] tick_reg;
  logic [6:0]  memidx_reg;
  logic [55:0] shift_reg;
  logic [5:0]  nbits_reg;
  logic [23:0] acc_cnt_reg;
  logic        unlocked_reg;
  logic [18:0] wait_reg;
  logic [50:0] tx_reg;
  logic [5:0]  txn_reg;
  logic        half_reg;
  logic [15:0] hcnt_reg;
  logic [1:0]  pclass_reg;
  logic [15:0] pcyc_reg;
  logic [7:0]  pticks_reg;
  logic        pin_q_reg;
  logic        prog_q_reg;

  // receiver
  logic        rx_bit_valid;
  logic        rx_bit_val;
  logic        rx_end;
  logic [15:0] rx_bit_time;
  logic [2:0]  rx_crc;
  logic        rx_clear;
  assign rx_clear = ~prog_enable | rx_end;
  mpi_rx u_rx (
    .clk       (clk),
    .resetn    (resetn),
    .enable    (prog_enable & ~pin_oe),
    .line      (pin_in),
    .bit_valid (rx_bit_valid),
    .bit_val   (rx_bit_val),
    .frame_end (rx_end),
    .bit_time  (rx_bit_time)
  );
  mpi_crc3 u_crc (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (rx_clear),
    .bit_valid (rx_bit_valid),
    .bit_val   (rx_bit_val),
    .crc       (rx_crc)
  );

  // field decode, fields counted msb first from the frame tail
  logic        f_read;
  logic [3:0]  f_cs;
  logic [1:0]  f_fs;
  logic [6:0]  f_addr;
  logic [31:0] f_data;
  logic        f_len_ok;
  logic        f_cs_ok;
  logic        f_ok;
  logic        f_access;
  logic        f_write;
  logic        f_is_nv;
  logic [31:0] f_rdata;
  assign f_read   = (nbits_reg == RD_FRAME_BITS) ? shift_reg[16] : shift_reg[48];
  assign f_cs     = (nbits_reg == RD_FRAME_BITS) ? shift_reg[15:12] : shift_reg[47:44];
  assign f_fs     = (nbits_reg == RD_FRAME_BITS) ? shift_reg[11:10] : shift_reg[43:42];
  assign f_addr   = (nbits_reg == RD_FRAME_BITS) ? shift_reg[9:3] : shift_reg[41:35];
  assign f_data   = shift_reg[34:3];
  // read has no data, writes carry 32 bits
  assign f_len_ok = (nbits_reg == RD_FRAME_BITS) ? f_read :
                    (nbits_reg == WR_FRAME_BITS) ? ~f_read : 1'b0;
  assign f_cs_ok  = (f_cs == 4'h0) || (f_cs == 4'hf) || f_cs[ctrl_reg[1:0]];
  assign f_ok     = rx_end && f_len_ok && f_cs_ok && (rx_crc == 3'h0)
                    && (f_fs != 2'h3);
  assign f_access = ~f_read && (f_addr == ACCESS_ADDR);
  assign f_write  = f_ok && ~f_read && ~f_access && unlocked_reg;
  assign f_is_nv  = (f_addr <= NV_LAST);
  assign f_rdata  = (f_fs == FS_LOW)  ? {20'h0, mem_reg[f_addr][11:0]} :
                    (f_fs == FS_HIGH) ? {6'h0, mem_reg[f_addr][25:12], 12'h0} :
                    mem_reg[f_addr];

  logic [45:0] tx_body;
  assign tx_body = {1'b1, 4'h1 << ctrl_reg[1:0], f_fs, f_addr, f_rdata};

  // tx half-bit timing at the measured rate
  logic [15:0] half_len;
  logic        half_done;
  logic        wait_done;
  assign half_len  = (rx_bit_time[15:1] == 15'h0) ? 16'h1 : {1'b0, rx_bit_time[15:1]};
  assign half_done = (hcnt_reg + 16'h1 >= half_len);
  assign wait_done = (wait_reg == 19'(NV_WRITE_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MPI_IDLE:   if (prog_enable) state_next = MPI_RX;
      MPI_RX: begin
        if (!prog_enable) state_next = MPI_IDLE;
        else if (f_write && f_is_nv) state_next = MPI_NVWAIT;
        else if (f_ok && f_read) state_next = MPI_TX;
      end
      MPI_NVWAIT: if (wait_done) state_next = MPI_ACKHI;
      MPI_ACKHI:  if (half_done && half_reg) state_next = MPI_ACKLO;
      MPI_ACKLO:  if (half_done && half_reg) state_next = MPI_RX;
      MPI_TX:     if (half_done && half_reg && txn_reg == 6'h0) state_next = MPI_RX;
      default:    state_next = MPI_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= MPI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // frame shift, the sync bits never reach it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 56'h0;
      nbits_reg <= 6'h0;
    end else if (rx_clear) begin
      nbits_reg <= 6'h0;
    end else if (rx_bit_valid) begin
      shift_reg <= {shift_reg[54:0], rx_bit_val};
      if (nbits_reg != 6'h3f) nbits_reg <= nbits_reg + 6'h1;
    end
  end

  // unlock window after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_cnt_reg  <= 24'h0;
      unlocked_reg <= 1'b0;
    end else begin
      if (acc_cnt_reg != 24'(ACCESS_CYCLES)) acc_cnt_reg <= acc_cnt_reg + 24'h1;
      if (f_ok && f_access && f_data == CUST_CODE && acc_cnt_reg != 24'(ACCESS_CYCLES))
        unlocked_reg <= 1'b1;
    end
  end

  // eeprom store time and reply timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg <= 19'h0;
      hcnt_reg <= 16'h0;
      half_reg <= 1'b0;
      txn_reg  <= 6'h0;
      tx_reg   <= 51'h0;
    end else begin
      wait_reg <= (state_reg == MPI_NVWAIT) ? wait_reg + 19'h1 : 19'h0;
      if (state_reg == MPI_RX && state_next == MPI_TX) begin
        tx_reg   <= {2'h0, tx_body, mpi_crc_fn(tx_body)};
        txn_reg  <= 6'(TX_BITS - 1);
        hcnt_reg <= 16'h0;
        half_reg <= 1'b0;
      end else if (state_reg == MPI_NVWAIT || state_reg == MPI_RX || state_reg == MPI_IDLE) begin
        hcnt_reg <= 16'h0;
        half_reg <= 1'b0;
      end else if (half_done) begin
        hcnt_reg <= 16'h0;
        half_reg <= ~half_reg;
        if (half_reg && state_reg == MPI_TX) begin
          tx_reg  <= {tx_reg[49:0], 1'b0};
          txn_reg <= txn_reg - 6'h1;
        end
      end else begin
        hcnt_reg <= hcnt_reg + 16'h1;
      end
    end
  end

  // pin drive: sensor level outside program mode unless poll mode, reply frames inside
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out    <= 1'b0;
      pin_oe     <= 1'b0;
      prog_q_reg <= 1'b0;
    end else begin
      prog_q_reg <= prog_enable;
      case (state_reg)
        MPI_TX: begin
          pin_oe  <= 1'b1;
          pin_out <= half_reg ? ~tx_reg[50] : tx_reg[50];
        end
        MPI_ACKHI: begin
          pin_oe  <= 1'b1;
          pin_out <= 1'b1;
        end
        MPI_ACKLO: begin
          pin_oe  <= 1'b1;
          pin_out <= 1'b0;
        end
        MPI_IDLE: begin
          pin_oe  <= ~prog_enable & ~ctrl_reg[2];
          pin_out <= sensor_level;
        end
        default: begin
          pin_oe  <= 1'b0;
          pin_out <= 1'b0;
        end
      endcase
    end
  end

  // poll mode: host low pulses measured in ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q_reg  <= 1'b1;
      pcyc_reg   <= 16'h0;
      pticks_reg <= 8'h0;
      pclass_reg <= PC_NONE;
    end else begin
      pin_q_reg <= pin_in;
      if (!ctrl_reg[2] || prog_enable || pin_in) begin
        pcyc_reg   <= 16'h0;
        pticks_reg <= 8'h0;
      end else if (pcyc_reg + 16'h1 >= tick_reg) begin
        pcyc_reg <= 16'h0;
        if (pticks_reg != 8'hff) pticks_reg <= pticks_reg + 8'h1;
      end else begin
        pcyc_reg <= pcyc_reg + 16'h1;
      end
      if (ctrl_reg[2] && !prog_enable && pin_in && !pin_q_reg) begin
        if (pticks_reg >= OUT_MIN && pticks_reg <= OUT_MAX) pclass_reg <= PC_OUTPUT;
        else if (pticks_reg >= SMP_MIN && pticks_reg <= SMP_MAX) pclass_reg <= PC_SAMPLE;
        else if (pticks_reg >= DIA_MIN && pticks_reg <= DIA_MAX) pclass_reg <= PC_DIAG;
        else pclass_reg <= PC_NONE;
      end
    end
  end

  // apb: one access phase, no wait
  logic        apb_setup;
  logic        apb_wr;
  logic [7:0]  apb_ofs;
  logic        apb_hit;
  logic [31:0] apb_rd;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite & ~pslverr;
  assign apb_ofs   = paddr[7:0];
  assign apb_hit   = (paddr[31:8] == 24'h0) && (apb_ofs[1:0] == 2'h0) && (apb_ofs <= OFS_BITTIME);
  assign apb_rd    = (apb_ofs == OFS_CTRL)    ? {29'h0, ctrl_reg} :
                     (apb_ofs == OFS_TICK)    ? {16'h0, tick_reg} :
                     (apb_ofs == OFS_STATUS)  ? {26'h0, pclass_reg, state_reg == MPI_TX,
                                                 state_reg == MPI_NVWAIT, unlocked_reg, prog_q_reg} :
                     (apb_ofs == OFS_MEMIDX)  ? {25'h0, memidx_reg} :
                     (apb_ofs == OFS_MEMDATA) ? mem_reg[memidx_reg] :
                     {16'h0, rx_bit_time};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0;
      ctrl_reg   <= CTRL_RST;
      tick_reg   <= TICK_RST;
      memidx_reg <= 7'h0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~apb_hit;
      prdata  <= (apb_setup && apb_hit && !pwrite) ? apb_rd : 32'h0;
      if (apb_wr && apb_ofs == OFS_CTRL)   ctrl_reg   <= pwdata[2:0];
      if (apb_wr && apb_ofs == OFS_TICK)   tick_reg   <= pwdata[15:0];
      if (apb_wr && apb_ofs == OFS_MEMIDX) memidx_reg <= pwdata[6:0];
    end
  end

  // memory words; a frame write wins over a same-cycle apb write
  generate
    for (genvar g = 0; g < 128; g++) begin : g_mem
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem_reg[g] <= 32'h0;
        end else if (f_write && f_addr == 7'(g)) begin
          mem_reg[g] <= mpi_merge(mem_reg[g], f_data, f_fs);
        end else if (apb_wr && apb_ofs == OFS_MEMDATA && memidx_reg == 7'(g)) begin
          mem_reg[g] <= pwdata;
        end
      end
    end
  endgenerate
endmodule

// ==== bench/mpi_top_assertions.sv ====
// checker: apb timing and pin ownership at the top ports
// assumes a bind to the top module, ports watched only
`timescale 1ns/100ps
module mpi_chk #(
  parameter int unsigned NV_WRITE_CYCLES = 400000,
  parameter int unsigned ACCESS_CYCLES   = 10000000
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin side
  input wire logic        prog_enable,
  input wire logic        sensor_level,
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe
);
  logic setup_q;
  logic poll_q;
  // ready is legal only right after a setup cycle
  // poll mode bit tracked from control writes, the pin is released then
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setup_q <= 1'b0;
      poll_q  <= 1'b0;
    end else begin
      setup_q <= psel & ~penable;
      if (psel && penable && pready && pwrite && !pslverr && paddr == 32'h0)
        poll_q <= pwdata[2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_cause; pready |-> setup_q; endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_quiet; prdata != 32'h0 |-> pready; endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside access");
  property p_unmap; psel && !penable && paddr > 32'h14 |=> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped address accepted");
  property p_map; psel && !penable && paddr <= 32'h14 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped address refused");
  property p_release; $rose(prog_enable) |=> !pin_oe [*8]; endproperty
  a_release: assert property (p_release) else $error("pin driven in program mode");
  property p_normal;
    (!prog_enable && !poll_q) [*3] |-> pin_oe && pin_out == $past(sensor_level);
  endproperty
  a_normal: assert property (p_normal) else $error("sensor drive missing");
  property p_poll; (poll_q && !prog_enable) [*2] |-> !pin_oe; endproperty
  a_poll: assert property (p_poll) else $error("pin driven in poll mode");
  c_reply: cover property (prog_enable && $rose(pin_oe));
  c_slverr: cover property (pslverr);
  c_leave: cover property ($fell(prog_enable));
endmodule

bind mpi_top mpi_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES), .ACCESS_CYCLES(ACCESS_CYCLES))
  u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
         .pslverr, .prog_enable, .sensor_level, .pin_in, .pin_out, .pin_oe);

// ==== bench/mpi_host_model.sv ====
// host model: programming controller on supply and data line
// assumes the bench resolves the shared line and feeds it back
`timescale 1ns/100ps
module mpi_host_model (
  // clock
  input  wire logic        clk,
  // line level at the pin
  input  wire logic        line,
  // host drive
  output logic             prog_enable,
  output logic             host_out,
  output logic             host_oe,
  // decoded reply
  output logic             rx_valid,
  output logic [50:0]      rx_word
);
  int unsigned half = 100;
  initial begin
    prog_enable = 1'b0;
    host_out    = 1'b0;
    host_oe     = 1'b0;
    rx_valid    = 1'b0;
    rx_word     = '0;
  end
  // program mode, line low, sync then body msb first
  task automatic send(input logic [63:0] fr, input int n);
    @(posedge clk);
    prog_enable <= 1'b1;
    host_oe     <= 1'b1;
    host_out    <= 1'b0;
    repeat (4200) @(posedge clk);
    for (int i = n + 1; i >= 0; i--) begin
      host_out <= (i < n) ? fr[i] : 1'b0;
      repeat (half) @(posedge clk);
      host_out <= (i < n) ? ~fr[i] : 1'b1;
      repeat (half) @(posedge clk);
    end
    host_oe <= 1'b0;
  endtask
  // nothing new is sent until a reply is over or the wait ran out
  task automatic listen(input int limit, output logic got);
    int k;
    k = 0;
    // own release first, so a low last half is not taken for a reply
    @(posedge clk);
    while (line !== 1'b0 && k < limit) begin
      @(posedge clk);
      k++;
    end
    got = (line === 1'b0);
    if (got) begin
      repeat (half / 2) @(posedge clk);
      for (int i = 50; i >= 0; i--) begin
        rx_word[i] <= line;
        repeat (2 * half) @(posedge clk);
      end
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
    end
  endtask
  task automatic leave();
    @(posedge clk);
    prog_enable <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // low pulse on the released line, for poll mode
  task automatic pulse(input int len);
    @(posedge clk);
    host_oe  <= 1'b1;
    host_out <= 1'b0;
    repeat (len) @(posedge clk);
    host_oe  <= 1'b0;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// testbench: registers over apb, host frames on the programming pin
// assumes package, host model and bound checker compiled before it
`timescale 1ns/100ps
module tb_top;
  import mpi_pkg::*;
  localparam int NV_TB = 200;
  logic        clk = 1'b0;
  logic        resetn, psel, penable, pwrite, sensor_level;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr, pin_out, pin_oe;
  logic        prog_enable, host_out, host_oe, rx_valid;
  logic [50:0] rx_word;
  logic [63:0] eq[$];
  int          err_count, compares, cyc;
  // a released line is pulled high
  wire         pin_in = host_oe ? host_out : (pin_oe ? pin_out : 1'b1);

  mpi_top #(.NV_WRITE_CYCLES(NV_TB), .ACCESS_CYCLES(60000)) uut (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prog_enable, .sensor_level, .pin_in, .pin_out, .pin_oe);
  mpi_host_model host (.clk, .line(pin_in), .prog_enable, .host_out, .host_oe,
    .rx_valid, .rx_word);

  always #25 clk = ~clk;
  always @(posedge clk) sensor_level <= 1'($urandom);

  task automatic complete_run();
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic take(input logic [63:0] got);
    chk(got, (eq.size() > 0) ? eq.pop_front() : 64'hx);
  endtask
  // results are matched against the oldest note as they appear
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 150000) begin
      err_count++;
      complete_run();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) take({32'h0, prdata});
    if (rx_valid === 1'b1) take(64'(rx_word));
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    eq.push_back({32'h0, exp});
    apb(1'b0, a, 32'h0);
  endtask
  // check bits appended so the remainder ends at zero
  function automatic logic [63:0] seal(input logic [63:0] b, input int n);
    logic [2:0] c;
    logic       fb;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[2] ^ b[i];
      c  = {c[1], c[0] ^ fb, fb};
    end
    return {b[60:0], c};
  endfunction
  task automatic frame(input logic [63:0] fr, input int n, input logic reply);
    logic got;
    host.send(fr, n);
    host.listen(8 * host.half, got);
    chk({63'h0, got}, {63'h0, reply});
    host.leave();
  endtask

  initial begin
    logic [31:0] v, d, e;
    int          t0, n;
    void'($urandom(63264));
    {resetn, psel, penable, pwrite, sensor_level} = 5'h0;
    paddr  = 32'h0;
    pwdata = 32'h0;
    host.half = 100 + $urandom % 11;
    v = $urandom;
    d = $urandom;
    e = $urandom;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd(32'(OFS_TICK), 32'(TICK_RST));
    rd(32'(OFS_STATUS), 32'h0);
    rd(32'h18, 32'h0);
    apb(1'b1, 32'(OFS_CTRL), 32'h2);
    rd(32'(OFS_CTRL), 32'h2);
    apb(1'b1, 32'(OFS_MEMIDX), 32'h41);
    apb(1'b1, 32'(OFS_MEMDATA), v);
    frame(seal({1'b0, 4'h0, FS_ALL, ACCESS_ADDR, CUST_CODE}, 46), 49, 1'b0);
    rd(32'(OFS_STATUS), 32'h2);
    frame(seal({1'b0, 4'h4, FS_LOW, 7'h41, d}, 46), 49, 1'b0);
    rd(32'(OFS_MEMDATA), {v[31:12], d[11:0]});
    rd(32'(OFS_BITTIME), 32'(2 * host.half));
    eq.push_back(seal({1'b1, 4'h4, FS_HIGH, 7'h41, v & 32'h03fff000}, 46));
    frame(seal({1'b1, 4'h4, FS_HIGH, 7'h41}, 14), 17, 1'b1);
    frame(seal({1'b1, 4'hb, FS_ALL, 7'h41}, 14), 17, 1'b0);
    frame(seal({1'b1, 4'hf, FS_ALL, 7'h41}, 14) ^ 64'h1, 17, 1'b0);
    host.send(seal({1'b0, 4'hf, FS_ALL, 7'h05, e}, 46), 49);
    t0 = cyc;
    while (pin_oe !== 1'b1) @(posedge clk);
    chk(64'(cyc - t0 >= NV_TB && cyc - t0 < NV_TB + 8 * host.half), 64'h1);
    chk({63'h0, pin_out}, 64'h1);
    while (pin_out === 1'b1) @(posedge clk);
    chk({62'h0, pin_oe, pin_out}, 64'h2);
    // the low half lasts a whole bit; leave only once the pin is released
    while (pin_oe === 1'b1) @(posedge clk);
    host.leave();
    apb(1'b1, 32'(OFS_MEMIDX), 32'h05);
    rd(32'(OFS_MEMDATA), e);
    // poll mode, ticks of four cycles, one pulse per class
    apb(1'b1, 32'(OFS_CTRL), 32'h6);
    apb(1'b1, 32'(OFS_TICK), 32'h4);
    for (int k = 1; k <= 3; k++) begin
      n = (k == 1) ? OUT_MIN + $urandom % 5 : (k == 2) ? SMP_MIN + $urandom % 9 :
          DIA_MIN + $urandom % 15;
      host.pulse(4 * n + 1);
      rd(32'(OFS_STATUS), 32'h2 | 32'(k << 4));
    end
    complete_run();
  end
endmodule
